/* File: include/emb_defines.vh */
// Shared constants for the external memory bus control block.
`ifndef EMB_DEFINES_VH
`define EMB_DEFINES_VH
`define EMB_SPACE_DATA     2'h0
`define EMB_SPACE_PROG     2'h1
`define EMB_SPACE_IO       2'h2
`define EMB_WS_W           3
`define EMB_WS_MIN_READY   3'h2
`define EMB_MC_DIV         4
`define EMB_MC_CNT_W       2
`define EMB_ADDR_W         23
`define EMB_DATA_W         16
`define EMB_SYNC_W         3
`endif

/* File: src/emb_sync.v */
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`include "emb_defines.vh"
module emb_sync #(
  parameter RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire clock,
  input  wire rst_n,
  // Pin and result
  input  wire pin_in,
  output reg  level_out
);
  reg [`EMB_SYNC_W-1:0] stage_r;

  always @(posedge clock) begin
    if (!rst_n) begin
      stage_r   <= {`EMB_SYNC_W{RESET_VAL}};
      level_out <= RESET_VAL;
    end else begin
      stage_r <= {stage_r[`EMB_SYNC_W-2:0], pin_in};
      if (stage_r[1] == stage_r[2]) begin
        level_out <= stage_r[2];
      end
    end
  end
endmodule // emb_sync

/* File: src/emb_mc_div.v */
// Machine-cycle enable divider: one-cycle pulse every EMB_MC_DIV clocks.
`timescale 1ns/1ps
`include "emb_defines.vh"
module emb_mc_div (
  // Clock and reset
  input  wire clock,
  input  wire rst_n,
  // Machine-cycle enable
  output reg  mc_tick
);
  reg [`EMB_MC_CNT_W-1:0] cnt_r;

  always @(posedge clock) begin
    if (!rst_n) begin
      cnt_r   <= {`EMB_MC_CNT_W{1'b0}};
      mc_tick <= 1'b0;
    end else begin
      cnt_r   <= cnt_r + {{(`EMB_MC_CNT_W-1){1'b0}}, 1'b1};
      mc_tick <= (cnt_r == {`EMB_MC_CNT_W{1'b1}});
    end
  end
endmodule // emb_mc_div

/* File: src/emb_bus_ctrl.v */
// External memory bus control: space selects, strobes, direction, wait states, ready and hold.
// Operation
// - Each space select rests high and goes low only while its own external space is accessed.
// - A space select is low only while the address bus carries the valid address of the access.
// - The memory strobe goes low only for external data or program memory accesses.
// - The I/O strobe goes low only for external I/O accesses.
// - The direction line rests high for read and is low only during an external write.
// - While ready samples low, the access is stretched one machine cycle and ready is sampled again.
// - Ready is only examined when two or more software wait states are programmed.
// - Ready is not sampled before all programmed software wait states have finished.
// - A hold request from another master is accepted and then address, data and control float.
// - The release acknowledge is high exactly while the block is in hold with the lines floating.
// - In hold the space selects, strobes and direction line float.
// - While tristate_all_n is low the selects, strobes, direction and acknowledge all float.
// - With two or more wait states, wait_state_done goes low at the first and high at the last.
// - The data bus floats unless driving a write, and whenever reset or hold request is active.
`timescale 1ns/1ps
`include "emb_defines.vh"
module emb_bus_ctrl #(
  parameter ADDR_W = `EMB_ADDR_W,
  parameter DATA_W = `EMB_DATA_W,
  parameter WS_W   = `EMB_WS_W
) (
  // Clock and reset
  input  wire              clock,
  input  wire              rst_n,
  // Core access request
  input  wire              req_valid,
  output reg               req_ready,
  input  wire [1:0]        req_space,
  input  wire              req_write,
  input  wire [ADDR_W-1:0] req_addr,
  input  wire [DATA_W-1:0] req_wdata,
  input  wire [WS_W-1:0]   req_wait_states,
  output reg               rsp_valid,
  output reg  [DATA_W-1:0] rsp_rdata,
  // External pins, inputs
  input  wire              ready_pin,
  input  wire              bus_release_request_n,
  input  wire              tristate_all_n,
  input  wire              device_reset_n,
  input  wire [DATA_W-1:0] data_in,
  // Address and data outputs
  output reg  [ADDR_W-1:0] addr_out,
  output reg               addr_oe,
  output reg  [DATA_W-1:0] data_out,
  output reg               data_oe,
  // Control outputs
  output reg               data_space_select_n,
  output reg               program_space_select_n,
  output reg               io_space_select_n,
  output reg               memory_strobe_n,
  output reg               io_strobe_n,
  output reg               rw_n,
  output reg               ctrl_oe,
  output reg               wait_state_done,
  output reg               wait_state_done_oe,
  output reg               bus_release_ack,
  output reg               bus_release_ack_oe
);
  localparam ST_IDLE = 5'h01;
  localparam ST_ADDR = 5'h02;
  localparam ST_WAIT = 5'h04;
  localparam ST_RDY  = 5'h08;
  localparam ST_HOLD = 5'h10;

  wire mc_tick;
  wire ready_s;
  wire hold_req_n_s;
  wire off_n_s;
  wire rst_pin_n_s;

  emb_mc_div u_div (
    .clock   (clock),
    .rst_n   (rst_n),
    .mc_tick (mc_tick)
  );

  emb_sync #(.RESET_VAL(1'b0)) u_sync_rdy (
    .clock     (clock),
    .rst_n     (rst_n),
    .pin_in    (ready_pin),
    .level_out (ready_s)
  );

  emb_sync #(.RESET_VAL(1'b1)) u_sync_hold (
    .clock     (clock),
    .rst_n     (rst_n),
    .pin_in    (bus_release_request_n),
    .level_out (hold_req_n_s)
  );

  emb_sync #(.RESET_VAL(1'b1)) u_sync_off (
    .clock     (clock),
    .rst_n     (rst_n),
    .pin_in    (tristate_all_n),
    .level_out (off_n_s)
  );

  emb_sync #(.RESET_VAL(1'b0)) u_sync_rst (
    .clock     (clock),
    .rst_n     (rst_n),
    .pin_in    (device_reset_n),
    .level_out (rst_pin_n_s)
  );

  reg [4:0]        state_r;
  reg [1:0]        space_r;
  reg              write_r;
  reg [WS_W-1:0]   ws_left_r;
  reg              use_ready_r;

  // Select pattern for one space; all high when inactive.
  function [2:0] sel_dec;
    input [1:0] sp;
    input       act;
    begin
      sel_dec = 3'h7;
      if (act) begin
        case (sp)
          `EMB_SPACE_DATA: sel_dec = 3'h6;
          `EMB_SPACE_PROG: sel_dec = 3'h5;
          `EMB_SPACE_IO:   sel_dec = 3'h3;
          default:         sel_dec = 3'h7;
        endcase
      end
    end
  endfunction

  // Strobe pattern {io, memory} for one space, active low.
  // Data and program share the memory strobe; an undefined space asserts neither strobe.
  function [1:0] strb_dec;
    input [1:0] sp;
    input       act;
    begin
      strb_dec = 2'h3;
      if (act) begin
        case (sp)
          `EMB_SPACE_DATA: strb_dec = 2'h2;
          `EMB_SPACE_PROG: strb_dec = 2'h2;
          `EMB_SPACE_IO:   strb_dec = 2'h1;
          default:         strb_dec = 2'h3;
        endcase
      end
    end
  endfunction

  wire       in_access = (state_r == ST_ADDR) || (state_r == ST_WAIT) || (state_r == ST_RDY);
  wire [2:0] sel_n     = sel_dec(space_r, in_access);
  wire [1:0] strb_n    = strb_dec(space_r, in_access);
  // An access to an undefined space runs its cycles but never marks the bus, so no strobe,
  // direction or data drive can appear outside a space select.
  wire       ext_act   = ~&sel_n;
  wire       ws_first  = req_wait_states >= `EMB_WS_MIN_READY;

  always @(posedge clock) begin
    if (!rst_n) begin
      state_r     <= ST_IDLE;
      space_r     <= `EMB_SPACE_DATA;
      write_r     <= 1'b0;
      ws_left_r   <= {WS_W{1'b0}};
      use_ready_r <= 1'b0;
      addr_out    <= {ADDR_W{1'b0}};
      data_out    <= {DATA_W{1'b0}};
      req_ready   <= 1'b0;
      rsp_valid   <= 1'b0;
      rsp_rdata   <= {DATA_W{1'b0}};
      wait_state_done <= 1'b1;
    end else begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      // A device reset aborts an access but keeps a granted hold, so the other master is
      // never overrun while it owns the bus; the hold ends through its own release path.
      if (!rst_pin_n_s && (state_r != ST_HOLD)) begin
        state_r         <= ST_IDLE;
        wait_state_done <= 1'b1;
      end else if (mc_tick) begin
        case (state_r)
          ST_IDLE: begin
            if (!hold_req_n_s) begin
              state_r <= ST_HOLD;
            end else if (req_valid) begin
              space_r     <= req_space;
              write_r     <= req_write;
              addr_out    <= req_addr;
              data_out    <= req_wdata;
              ws_left_r   <= req_wait_states;
              use_ready_r <= ws_first;
              req_ready   <= 1'b1;
              state_r     <= ST_ADDR;
            end
          end
          ST_ADDR: begin
            if (ws_left_r != {WS_W{1'b0}}) begin
              state_r <= ST_WAIT;
              if (use_ready_r) begin
                wait_state_done <= 1'b0;
              end
              if (ws_left_r == {{(WS_W-1){1'b0}}, 1'b1} && use_ready_r) begin
                wait_state_done <= 1'b1;
              end
            end else begin
              state_r <= ST_IDLE;
              rsp_valid <= 1'b1;
              rsp_rdata <= data_in;
            end
          end
          ST_WAIT: begin
            ws_left_r <= ws_left_r - {{(WS_W-1){1'b0}}, 1'b1};
            if (ws_left_r == {{(WS_W-2){1'b0}}, 2'h2} && use_ready_r) begin
              wait_state_done <= 1'b1;
            end
            if (ws_left_r == {{(WS_W-1){1'b0}}, 1'b1}) begin
              if (use_ready_r) begin
                state_r <= ST_RDY;
              end else begin
                state_r   <= ST_IDLE;
                rsp_valid <= 1'b1;
                rsp_rdata <= data_in;
              end
            end
          end
          ST_RDY: begin
            if (ready_s) begin
              state_r   <= ST_IDLE;
              rsp_valid <= 1'b1;
              rsp_rdata <= data_in;
            end
          end
          ST_HOLD: begin
            if (hold_req_n_s) begin
              state_r <= ST_IDLE;
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  reg data_sel_n_nxt;
  reg prog_sel_n_nxt;
  reg io_sel_n_nxt;
  reg mem_strobe_n_nxt;
  reg io_strobe_n_nxt;
  reg rw_n_nxt;
  reg ctrl_oe_nxt;
  reg addr_oe_nxt;
  reg data_oe_nxt;
  reg wsd_oe_nxt;
  reg ack_nxt;
  reg ack_oe_nxt;

  // Next pin levels. Selects, strobes and direction all come from one decode of the state,
  // so none of them can lead another when the registers below add their clock of lag.
  always @* begin
    data_sel_n_nxt   = sel_n[0];
    prog_sel_n_nxt   = sel_n[1];
    io_sel_n_nxt     = sel_n[2];
    mem_strobe_n_nxt = strb_n[0];
    io_strobe_n_nxt  = strb_n[1];
    rw_n_nxt         = ~(ext_act && write_r);
    ctrl_oe_nxt      = off_n_s && (state_r != ST_HOLD);
    addr_oe_nxt      = off_n_s && (state_r != ST_HOLD);
    data_oe_nxt      = off_n_s && ext_act && write_r && rst_pin_n_s && hold_req_n_s;
    wsd_oe_nxt       = off_n_s;
    ack_nxt          = (state_r == ST_HOLD);
    ack_oe_nxt       = off_n_s;
  end

  // Pin drive and enables are registered so every output comes from a flip-flop.
  always @(posedge clock) begin
    if (!rst_n) begin
      data_space_select_n    <= 1'b1;
      program_space_select_n <= 1'b1;
      io_space_select_n      <= 1'b1;
      memory_strobe_n        <= 1'b1;
      io_strobe_n            <= 1'b1;
      rw_n                   <= 1'b1;
      ctrl_oe                <= 1'b1;
      addr_oe                <= 1'b1;
      data_oe                <= 1'b0;
      wait_state_done_oe     <= 1'b1;
      bus_release_ack        <= 1'b0;
      bus_release_ack_oe     <= 1'b1;
    end else begin
      data_space_select_n    <= data_sel_n_nxt;
      program_space_select_n <= prog_sel_n_nxt;
      io_space_select_n      <= io_sel_n_nxt;
      memory_strobe_n        <= mem_strobe_n_nxt;
      io_strobe_n            <= io_strobe_n_nxt;
      rw_n                   <= rw_n_nxt;
      ctrl_oe                <= ctrl_oe_nxt;
      addr_oe                <= addr_oe_nxt;
      data_oe                <= data_oe_nxt;
      wait_state_done_oe     <= wsd_oe_nxt;
      bus_release_ack        <= ack_nxt;
      bus_release_ack_oe     <= ack_oe_nxt;
    end
  end
endmodule // emb_bus_ctrl

/* File: tb/emb_bus_ctrl_assertions.sv */
// Concurrent checks on the bus control pins.
`timescale 1ns/1ps
module emb_chk (
  // Clock and reset
  input logic clock,
  input logic rst_n,
  // Pin inputs
  input logic tristate_all_n,
  input logic device_reset_n,
  input logic bus_release_request_n,
  // Pin outputs
  input logic data_space_select_n,
  input logic program_space_select_n,
  input logic io_space_select_n,
  input logic memory_strobe_n,
  input logic io_strobe_n,
  input logic rw_n,
  input logic ctrl_oe,
  input logic addr_oe,
  input logic data_oe,
  input logic wait_state_done,
  input logic bus_release_ack,
  input logic bus_release_ack_oe
);
  wire [2:0] sel_n = {data_space_select_n, program_space_select_n, io_space_select_n};
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_off; !tristate_all_n [*6]; endsequence
  sequence s_quiet; (!device_reset_n || !bus_release_request_n) [*6]; endsequence
  property p_one_sel; $onehot0(~sel_n); endproperty
  property p_memory_strobe_n; !memory_strobe_n |-> !data_space_select_n || !program_space_select_n; endproperty
  property p_io_strobe_n; !io_strobe_n |-> !io_space_select_n && memory_strobe_n; endproperty
  property p_rw; !rw_n |-> sel_n != 3'h7; endproperty
  property p_addr; sel_n != 3'h7 |-> ctrl_oe && addr_oe; endproperty
  property p_hold; bus_release_ack |-> !ctrl_oe && !addr_oe && !data_oe; endproperty
  property p_off; s_off |-> !ctrl_oe && !bus_release_ack_oe; endproperty
  property p_quiet; s_quiet |-> !data_oe; endproperty
  property p_wsd; !wait_state_done |-> sel_n != 3'h7; endproperty
  a_one_sel:
    assert property (p_one_sel) else $error("two selects");
  a_memory_strobe_n:
    assert property (p_memory_strobe_n) else $error("mem strobe");
  a_io_strobe_n:
    assert property (p_io_strobe_n) else $error("io strobe");
  a_rw:
    assert property (p_rw) else $error("write idle");
  a_addr:
    assert property (p_addr) else $error("no address");
  a_hold:
    assert property (p_hold) else $error("hold drive");
  a_off:
    assert property (p_off) else $error("off drive");
  a_quiet:
    assert property (p_quiet) else $error("data drive");
  a_wsd:
    assert property (p_wsd) else $error("wait idle");
endmodule // emb_chk
bind emb_bus_ctrl emb_chk emb_chk_inst (.clock, .rst_n, .tristate_all_n, .device_reset_n, .bus_release_request_n,
  .data_space_select_n, .program_space_select_n, .io_space_select_n, .memory_strobe_n, .io_strobe_n, .rw_n,
  .ctrl_oe, .addr_oe, .data_oe, .wait_state_done, .bus_release_ack, .bus_release_ack_oe);

/* File: tb/emb_ext_dev.sv */
// External device model: answers reads, records writes, stalls ready.
`timescale 1ns/1ps
module emb_ext_dev (
  input  logic        clock,
  input  logic        act,
  input  logic        rd,
  input  logic [15:0] addr,
  input  logic [15:0] wdata,
  input  logic [7:0]  stall,
  output logic        ready,
  output logic [15:0] rdata,
  output logic [15:0] wr_seen
);
  logic [7:0] cnt;
  initial {cnt, ready, rdata, wr_seen} = {8'h00, 1'b1, 32'h0};
  always @(posedge clock) begin
    cnt <= act ? cnt + 8'h01 : 8'h00;
    ready <= !act || cnt >= stall;
    rdata <= (act && rd) ? addr ^ 16'hA5A5 : ~rdata;
    if (act && !rd) wr_seen <= wdata;
  end
endmodule // emb_ext_dev

/* File: tb/emb_bus_ctrl_tb.sv */
// Self-checking bench for the external memory bus control block.
`timescale 1ns/1ps
module emb_bus_ctrl_tb;
  logic clock, rst_n, req_valid, req_write, ready_pin, bus_release_request_n, tristate_all_n, device_reset_n;
  logic [1:0] req_space;
  logic [2:0] req_wait_states;
  logic [22:0] req_addr;
  logic [15:0] req_wdata, data_in;
  logic [7:0] stall;
  wire logic req_ready, rsp_valid, addr_oe, data_oe, data_space_select_n, program_space_select_n, io_space_select_n;
  wire logic memory_strobe_n, io_strobe_n, rw_n, ctrl_oe, wait_state_done, wait_state_done_oe;
  wire logic bus_release_ack, bus_release_ack_oe;
  wire logic [15:0] rsp_rdata, data_out, wr_seen;
  wire logic [22:0] addr_out;
  wire act = ctrl_oe && !(data_space_select_n && program_space_select_n && io_space_select_n);
  int n_fail, checked;
  logic r;
  emb_bus_ctrl emb_bus_ctrl_inst (.clock, .rst_n, .req_valid, .req_ready, .req_space, .req_write, .req_addr,
    .req_wdata, .req_wait_states, .rsp_valid, .rsp_rdata, .ready_pin, .bus_release_request_n, .tristate_all_n,
    .device_reset_n, .data_in, .addr_out, .addr_oe, .data_out, .data_oe, .data_space_select_n,
    .program_space_select_n, .io_space_select_n, .memory_strobe_n, .io_strobe_n, .rw_n, .ctrl_oe,
    .wait_state_done, .wait_state_done_oe, .bus_release_ack, .bus_release_ack_oe);
  emb_ext_dev emb_ext_dev_inst (.clock, .act, .rd(rw_n || !data_oe), .addr(addr_out[15:0]), .wdata(data_out),
    .stall, .ready(ready_pin), .rdata(data_in), .wr_seen);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  function automatic logic [15:0] exp_rdata(input logic [15:0] a);
    return a ^ 16'hA5A5;
  endfunction
  function automatic int wsd_low_clocks(input int ws);
    return ws >= 2 ? 4 * (ws - 1) : 0;
  endfunction
  task automatic print_verdict();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic start(input int sp, input int w, input int ws, input int st);
    @(posedge clock);
    {req_space, req_write, req_wait_states, stall} <= {2'(sp), 1'(w), 3'(ws), 8'(st)};
    {req_addr, req_wdata, req_valid} <= {23'($urandom), 16'($urandom), 1'b1};
  endtask
  task automatic take();
    for (int k = 0; k < 200 && req_ready !== 1'b1; k++) @(negedge clock);
    @(posedge clock);
    req_valid <= 1'b0;
  endtask
  task automatic fin();
    int lat, lo, wlo;
    logic [7:0] seen;
    logic ext_wr;
    lat = 0;
    wlo = 0;
    seen = '0;
    take();
    while (rsp_valid !== 1'b1 && lat < 400) begin
      @(negedge clock);
      lat++;
      seen |= {~{data_space_select_n, program_space_select_n, io_space_select_n, memory_strobe_n, io_strobe_n,
        rw_n, wait_state_done}, data_oe};
      wlo += (wait_state_done === 1'b0);
    end
    ext_wr = req_write && req_space != 3;
    lo = 4 * (req_wait_states + 1);
    if (req_wait_states >= 2 && stall > lo) lo = stall;
    chk(seen, {req_space == 0, req_space == 1, req_space == 2, req_space < 2, req_space == 2, ext_wr,
      req_wait_states >= 2, ext_wr}, "pins");
    chk(lat >= lo - 4 && lat <= lo + 16, 1, "length");
    chk(wlo, wsd_low_clocks(req_wait_states), "wsd length");
    if (ext_wr) chk(wr_seen, req_wdata, "wdata");
    else if (req_space != 3) chk(rsp_rdata, exp_rdata(req_addr[15:0]), "rdata");
  endtask
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    #100000;
    n_fail++;
    print_verdict();
  end
  initial begin
    {rst_n, req_valid, req_write, req_space, req_wait_states, req_addr, req_wdata, stall} = '0;
    {bus_release_request_n, tristate_all_n, device_reset_n} = 3'h7;
    void'($urandom(32'h6A61));
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (8) @(posedge clock);
    for (int i = 0; i < 24; i++) begin
      start(i % 3, (i / 3) % 2, i < 8 ? i : $urandom % 8, i < 4 ? 60 : $urandom % 48);
      fin();
    end
    start(3, 1, 0, 0);
    fin();
    $display("access mix done");
    @(posedge clock);
    bus_release_request_n <= 1'b0;
    repeat (16) @(negedge clock);
    chk(bus_release_ack, 1, "ack");
    chk({ctrl_oe, addr_oe, data_oe}, 0, "hold drive");
    start(1, 1, 2, 8);
    r = 1'b0;
    repeat (40) @(negedge clock) r |= req_ready;
    chk(r, 0, "taken in hold");
    @(posedge clock);
    bus_release_request_n <= 1'b1;
    fin();
    $display("hold done");
    @(posedge clock);
    tristate_all_n <= 1'b0;
    repeat (10) @(negedge clock);
    chk({ctrl_oe, addr_oe, data_oe, wait_state_done_oe, bus_release_ack_oe}, 0, "off drive");
    @(posedge clock);
    tristate_all_n <= 1'b1;
    repeat (10) @(posedge clock);
    $display("off done");
    start(0, 1, 7, 0);
    take();
    device_reset_n <= 1'b0;
    repeat (8) @(negedge clock);
    chk(data_oe, 0, "data drive");
    @(posedge clock);
    device_reset_n <= 1'b1;
    repeat (12) @(posedge clock);
    start(2, 0, 3, 20);
    fin();
    $display("abort done");
    print_verdict();
  end
endmodule // emb_bus_ctrl_tb
